// file: design/pmr_pkg.sv
// Package of constants for the port measurement result registers.
package pmr_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int PORTS      = 4;
  localparam int PORT_W     = 2;
  localparam int SEL_W      = 4;
  localparam int RESULT_W   = 15;
  localparam int ADDR_W     = 8;

  // ****************************************************************
  // Register select codes, per port
  // ****************************************************************
  localparam logic [3:0] SEL_CUR_LOW  = 4'hA;
  localparam logic [3:0] SEL_CUR_HIGH = 4'hB;
  localparam logic [3:0] SEL_TMP_LOW  = 4'hC;
  localparam logic [3:0] SEL_TMP_HIGH = 4'hD;

  // ****************************************************************
  // Interrupt registers, outside the per-port select space
  // ****************************************************************
  localparam logic [3:0] SEL_IRQ_STATUS = 4'hE;
  localparam logic [3:0] SEL_IRQ_MASK   = 4'hF;
  localparam logic [1:0] IRQ_PORT       = 2'h0;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int DONE_BIT             = 7;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET   = 8'h00;

  typedef enum logic [0:0] {PMR_KIND_CUR, PMR_KIND_TMP} pmr_kind_t;

endpackage

// file: design/pmr_result_slot.sv
// One measurement result holder: 15-bit value and completion flag.
`timescale 1ns/1ns
`default_nettype none
module pmr_result_slot (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        conv_start,
  input  wire logic        conv_done,
  input  wire logic [14:0] conv_value,
  output var  logic [14:0] value_reg,
  output var  logic        done_reg,
  output var  logic        done_pulse
);

  // A new start clears the flag; a finish in the same cycle wins, since the result is then valid.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      done_reg <= 1'b0;
    end else if (conv_done) begin
      done_reg <= 1'b1;
    end else if (conv_start) begin
      done_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      value_reg <= 15'h0000;
    end else if (conv_done) begin
      value_reg <= conv_value;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      done_pulse <= 1'b0;
    end else begin
      done_pulse <= conv_done;
    end
  end

endmodule
`default_nettype wire

// file: design/pmr_irq.sv
// Sticky event status with write-one-to-clear, mask, and level interrupt.
`timescale 1ns/1ns
`default_nettype none
module pmr_irq (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] event_in,
  input  wire logic [7:0] clear_in,
  input  wire logic       mask_we,
  input  wire logic [7:0] mask_wdata,
  output var  logic [7:0] status_reg,
  output var  logic [7:0] mask_reg,
  output var  logic       irq_reg
);

  // A new event in the clearing cycle keeps its bit set.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      status_reg <= 8'h00;
    end else begin
      status_reg <= (status_reg & ~clear_in) | event_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mask_reg <= pmr_pkg::MASK_RESET;
    end else if (mask_we) begin
      mask_reg <= mask_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(((status_reg & ~clear_in) | event_in) & mask_reg);
    end
  end

endmodule
`default_nettype wire

// file: design/pmr_top.sv
// Top of the per-port current and temperature result registers.
// Summary of operation
// RULE_01 - Select 1010 returns current result bits 7..0 per port; resets to zero.
// RULE_02 - Select 1011 returns current result bits 14..8 in positions 6..0.
// RULE_03 - Current done flag, bit 7 of 1011, clears at start, sets at finish.
// RULE_04 - Select 1100 returns temperature result bits 7..0 per port; resets to zero.
// RULE_05 - Select 1101 returns temperature result bits 14..8 in positions 6..0.
// RULE_06 - Temperature done flag, bit 7 of 1101, clears at start, sets at finish.
// RULE_07 - All result registers are read-only; writes leave them unchanged.
// RULE_08 - Host waits for the done flag before joining low and high bytes.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module pmr_top (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [7:0]  reg_rdata,
  input  wire logic [3:0]  cur_start,
  input  wire logic [3:0]  cur_done,
  input  wire logic [59:0] cur_value,
  input  wire logic [3:0]  tmp_start,
  input  wire logic [3:0]  tmp_done,
  input  wire logic [59:0] tmp_value,
  output var  logic        irq
);

  // ****************************************************************
  // Result holders, one per port and kind
  // ****************************************************************
  logic [14:0] cur_val [pmr_pkg::PORTS];
  logic [14:0] tmp_val [pmr_pkg::PORTS];
  logic [3:0]  cur_flag;
  logic [3:0]  tmp_flag;
  logic [3:0]  cur_evt;
  logic [3:0]  tmp_evt;

  genvar p;
  generate
    for (p = 0; p < pmr_pkg::PORTS; p = p + 1) begin : g_port
      pmr_result_slot u_cur (   // [RULE_03]
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .conv_start (cur_start[p]),
        .conv_done  (cur_done[p]),
        .conv_value (cur_value[p*15 +: 15]),
        .value_reg  (cur_val[p]),
        .done_reg   (cur_flag[p]),
        .done_pulse (cur_evt[p])
      );
      pmr_result_slot u_tmp (   // [RULE_06]
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .conv_start (tmp_start[p]),
        .conv_done  (tmp_done[p]),
        .conv_value (tmp_value[p*15 +: 15]),
        .value_reg  (tmp_val[p]),
        .done_reg   (tmp_flag[p]),
        .done_pulse (tmp_evt[p])
      );
    end
  endgenerate

  // ****************************************************************
  // Interrupts: bits 3..0 current done, bits 7..4 temperature done
  // ****************************************************************
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic       irq_level;
  logic [1:0] a_port;
  logic [3:0] a_sel;
  logic       irq_space;

  assign a_port    = reg_addr[5:4];
  assign a_sel     = reg_addr[3:0];
  assign irq_space = (a_port == pmr_pkg::IRQ_PORT) && (reg_addr[7:6] == 2'h0);

  pmr_irq u_irq (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .event_in   ({tmp_evt, cur_evt}),
    .clear_in   ((reg_wr && irq_space && a_sel == pmr_pkg::SEL_IRQ_STATUS) ? reg_wdata : 8'h00),
    .mask_we    (reg_wr && irq_space && a_sel == pmr_pkg::SEL_IRQ_MASK),
    .mask_wdata (reg_wdata),
    .status_reg (irq_status),
    .mask_reg   (irq_mask),
    .irq_reg    (irq_level)
  );

  assign irq = irq_level;

  // ****************************************************************
  // Read port; writes to result selects have no path into any holder.
  // ****************************************************************
  logic [7:0] rdata_next;

  always_comb begin
    rdata_next = 8'h00;
    if (reg_addr[7:6] == 2'h0) begin
      case (a_sel)
        pmr_pkg::SEL_CUR_LOW:  rdata_next = cur_val[a_port][7:0];                    // [RULE_01]
        pmr_pkg::SEL_CUR_HIGH: rdata_next = {cur_flag[a_port], cur_val[a_port][14:8]}; // [RULE_02]
        pmr_pkg::SEL_TMP_LOW:  rdata_next = tmp_val[a_port][7:0];                    // [RULE_04]
        pmr_pkg::SEL_TMP_HIGH: rdata_next = {tmp_flag[a_port], tmp_val[a_port][14:8]}; // [RULE_05]
        pmr_pkg::SEL_IRQ_STATUS: rdata_next = irq_space ? irq_status : 8'h00;
        pmr_pkg::SEL_IRQ_MASK:   rdata_next = irq_space ? irq_mask : 8'h00;
        default:               rdata_next = 8'h00;
      endcase
    end
  end

  // Read data stands for exactly the cycle after the strobe. [RULE_07]
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= pmr_pkg::RESULT_RESET;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// file: sim/pmr_properties.sv
// Checker of read data and completion flags at the top ports.
`timescale 1ns/1ns
`default_nettype none
module pmr_checker (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [3:0]  cur_start,
  input wire logic [3:0]  cur_done,
  input wire logic [59:0] cur_value,
  input wire logic [3:0]  tmp_start,
  input wire logic [3:0]  tmp_done,
  input wire logic [59:0] tmp_value,
  input wire logic        irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_idle_rdata_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero");
  a_reset_clears: assert property ($fell(sys_rst) |-> reg_rdata == 8'h00 && !irq)
    else $error("not clear after reset");
  a_cur_low_value: assert property (cur_done[0] ##1 (reg_rd && reg_addr == 8'h0A)
    |=> reg_rdata == $past(cur_value[7:0], 2)) else $error("current low byte");
  a_cur_high_value: assert property (cur_done[0] ##1 (reg_rd && reg_addr == 8'h0B)
    |=> reg_rdata == {1'b1, $past(cur_value[14:8], 2)}) else $error("current high byte");
  a_cur_start_clear: assert property ((cur_start[0] && !cur_done[0])
    ##1 (reg_rd && reg_addr == 8'h0B) |=> !reg_rdata[7]) else $error("current flag");
  a_tmp_low_value: assert property (tmp_done[1] ##1 (reg_rd && reg_addr == 8'h1C)
    |=> reg_rdata == $past(tmp_value[22:15], 2)) else $error("temperature low byte");
  a_tmp_high_value: assert property (tmp_done[1] ##1 (reg_rd && reg_addr == 8'h1D)
    |=> reg_rdata == {1'b1, $past(tmp_value[29:23], 2)}) else $error("temperature high");
  a_tmp_start_clear: assert property ((tmp_start[1] && !tmp_done[1])
    ##1 (reg_rd && reg_addr == 8'h1D) |=> !reg_rdata[7]) else $error("temperature flag");
endmodule
bind pmr_top pmr_checker u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cur_start(cur_start), .cur_done(cur_done),
  .cur_value(cur_value), .tmp_start(tmp_start), .tmp_done(tmp_done),
  .tmp_value(tmp_value), .irq(irq));
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench of the port result registers.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic [3:0]  cur_start = 4'h0;
  logic [3:0]  cur_done = 4'h0;
  logic [59:0] cur_value = 60'h0;
  logic [3:0]  tmp_start = 4'h0;
  logic [3:0]  tmp_done = 4'h0;
  logic [59:0] tmp_value = 60'h0;
  logic        irq;
  int          num_errors = 0;
  int          checks = 0;
  always #10 sys_clk = ~sys_clk;
  pmr_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cur_start(cur_start), .cur_done(cur_done), .cur_value(cur_value),
    .tmp_start(tmp_start), .tmp_done(tmp_done), .tmp_value(tmp_value), .irq(irq));
  function automatic logic [14:0] fv(input int k, input int p);
    return 15'h4A5B ^ 15'(k * 15'h2301 + p * 15'h1111);
  endfunction
  function automatic logic [7:0] ex(input int k, input int p, input int hi, input logic f);
    logic [14:0] v;
    v = fv(k, p);
    return (hi != 0) ? {f, v[14:8]} : v[7:0];
  endfunction
  function automatic logic [7:0] ad(input int k, input int p, input int hi);
    return 8'(p * 16 + 10 + k * 2 + hi);
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_irq(input logic e);
    checks++;
    if (irq !== e) begin
      num_errors++;
      $display("BAD irq exp %b got %b", e, irq);
    end
  endtask
  // Every pulse vector is rewritten here, so one pulse never lingers.
  task automatic pulse(input int k, input int p, input logic s, input logic [14:0] v);
    @(posedge sys_clk);
    cur_start <= (k == 0 && s) ? 4'h1 << p : 4'h0;
    cur_done <= (k == 0 && !s) ? 4'h1 << p : 4'h0;
    tmp_start <= (k == 1 && s) ? 4'h1 << p : 4'h0;
    tmp_done <= (k == 1 && !s) ? 4'h1 << p : 4'h0;
    if (k == 0) cur_value[15*p +: 15] <= v;
    else tmp_value[15*p +: 15] <= v;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    {cur_start, cur_done, tmp_start, tmp_done} <= 16'h0000;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk("rdata", e, reg_rdata);
  endtask
  task automatic t_reset;
    for (int p = 0; p < 4; p++) begin
      for (int s = 0; s < 4; s++) begin
        rdchk(ad(0, p, s), 8'h00);
      end
    end
    rdchk(8'h40, 8'h00);
    chk_irq(1'b0);
    $display("reset test done");
  endtask
  task automatic t_conv;
    for (int k = 0; k < 2; k++) begin
      for (int p = 0; p < 4; p++) begin
        // The flag is read first, so the two bytes are only joined once it is high.
        pulse(k, p, 1'b0, fv(k, p));
        rdchk(ad(k, p, 1), ex(k, p, 1, 1'b1));
        pulse(k, p, 1'b0, fv(k, p));
        rdchk(ad(k, p, 0), ex(k, p, 0, 1'b1));
      end
    end
    $display("conversion test done");
  endtask
  task automatic t_ro;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ad(i / 2, 2, i % 2), 8'hFF);
      rdchk(ad(i / 2, 2, i % 2), ex(i / 2, 2, i % 2, 1'b1));
    end
    $display("read-only test done");
  endtask
  task automatic t_start;
    for (int k = 0; k < 2; k++) begin
      pulse(k, k, 1'b1, 15'h7FFF);
      rdchk(ad(k, k, 1), ex(k, k, 1, 1'b0));
      rdchk(ad(k, k, 0), ex(k, k, 0, 1'b0));
      pulse(k, k, 1'b0, fv(k, k));
      rdchk(ad(k, k, 1), ex(k, k, 1, 1'b1));
    end
    $display("start test done");
  endtask
  task automatic t_irq;
    bus(1'b1, 8'h0F, 8'h01);
    bus(1'b1, 8'h0E, 8'hFF);
    rdchk(8'h0F, 8'h01);
    chk_irq(1'b0);
    // The status bit lands a cycle after the result, so the mask is read in between.
    pulse(0, 0, 1'b0, fv(0, 0));
    rdchk(8'h0F, 8'h01);
    rdchk(8'h0E, 8'h01);
    chk_irq(1'b1);
    bus(1'b1, 8'h0E, 8'h01);
    rdchk(8'h0E, 8'h00);
    chk_irq(1'b0);
    pulse(1, 0, 1'b0, fv(1, 0));
    rdchk(8'h0F, 8'h01);
    rdchk(8'h0E, 8'h10);
    chk_irq(1'b0);
    $display("interrupt test done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset;
    t_conv;
    t_ro;
    t_start;
    t_irq;
    final_report;
  end
  // The run needs well under a thousand cycles, so this only catches a hang.
  initial begin
    #100000;
    num_errors++;
    final_report;
  end
endmodule
`default_nettype wire
